// ==== shared/fault_ctl_regs.svh ====
/*
  timing counts, field positions and reset values for the fault supervisor.
  assumes a 125 MHz core clock; included by bare name.
*/
`ifndef FAULT_CTL_REGS_SVH
`define FAULT_CTL_REGS_SVH

`define CLK_PERIOD_NS 8
`define RETRY_BASE_US 1000
`define RETRY_BASE_CYC ((`RETRY_BASE_US * 1000) / `CLK_PERIOD_NS)
`define RETRY_CNT_MAX 4'hF
`define CFG_RETRY_SEL_BIT 0
`define CFG_UNLIMITED_BIT 1
`define CFG_PERIOD_LSB 2
`define STAT_EXHAUST0_BIT 4
`define STAT_EXHAUST1_BIT 5
`define STAT_POR_BIT 6
`define STAT_UV_BIT 3
`define STAT_RESET_VAL 8'h40
`define SUP_SYNC_RESET_VAL 9'h008

`endif

// ==== shared/fault_ctl_pkg.sv ====
/*
  types shared by the fault supervisor modules.
  assumes nothing beyond a SystemVerilog compiler.
*/
package fault_ctl_pkg;
  typedef enum logic [2:0] {
    CH_OFF,
    CH_ON,
    CH_WAIT_CAUSE,
    CH_RETRY_WAIT,
    CH_LATCHED
  } ch_state_type;
endpackage : fault_ctl_pkg

// ==== design/sync2.sv ====
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes inputs are asynchronous levels; output lags by two edges.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("sync2: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL; // idle level of each pin
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

// ==== design/retry_timer.sv ====
/*
  per-channel retry period timer: counts the selected period after a start pulse.
  assumes start is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctl_regs.svh"
module retry_timer #(
  parameter int BASE_CYC = `RETRY_BASE_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [1:0] period_sel_in,
  output logic done_out
);
  localparam int CW = $clog2(BASE_CYC * 4 + 1);
  logic [CW-1:0] cnt_q;
  logic run_q;

  initial begin
    if (BASE_CYC < 1) $error("retry_timer: BASE_CYC must be at least 1");
  end

  // load period on start, pulse done when it runs out
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_q <= CW'(BASE_CYC * (int'(period_sel_in) + 1));
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= CW'(1)) begin
          run_q <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q - CW'(1);
        end
      end
    end
  end
endmodule : retry_timer
`default_nettype wire

// ==== design/fault_latch_retry_control.sv ====
/*
  fault supervision for a two-channel power switch: undervoltage latching,
  flag clearing, reset-occurred flag, retry condition and auto-retry.
  assumes analog comparators and pins arrive asynchronously; register
  read/write strobes come from a serial front end on mclk_in.
*/
// Notes on behaviour
// - undervoltage: both channels off, fault low, flag
// - uv gone, no request: fault high, flag kept
// - uv gone, request: on after delatch; read clears
// - auto-retry starts when undervoltage disappears
// - extended range keeps all register contents
// - below 6 V only overtemp; reported later
// - flags cleared on supply loss or read
// - fault switch-off uses fast rate
// - load ground loss open-load; system ground off
// - device ground high: link lost, fail-safe
// - serial access kept during undervoltage
// - supply rise from reset sets reset flag
// - wake with a supply up sets flag
// - no reset when logic supply stayed up
// - only latchable faults retry; uv/ot after cause
// - retry condition is OR of fault flags
// - retry follows config bits and remaining count
// - retry disabled: latchable faults latch immediately
// - retry after period chosen by two bits
// - limited retries: exhaust at 15, one more
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctl_regs.svh"
module fault_latch_retry_control
  import fault_ctl_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter int RETRY_BASE_CYC = `RETRY_BASE_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pwr_uv_in,
  input wire logic pwr_low6_in,
  input wire logic pwr_por_low_in,
  input wire logic logic_por_low_in,
  input wire logic logic_fail_in,
  input wire logic reset_wake_n_in,
  input wire logic [CHANNELS-1:0] direct_in,
  input wire logic load_gnd_loss_in,
  input wire logic sys_gnd_loss_in,
  input wire logic dev_gnd_high_in,
  input wire logic [CHANNELS-1:0] overcurrent_in,
  input wire logic [CHANNELS-1:0] short_circuit_in,
  input wire logic [CHANNELS-1:0] overtemp_in,
  input wire logic [CHANNELS-1:0] channel_on_request_in,
  input wire logic [CHANNELS-1:0] delatch_in,
  input wire logic status_read_in,
  input wire logic [3:0] retry_config_in,
  input wire logic retry_config_wr_in,
  input wire logic fast_sel_in,
  output logic [CHANNELS-1:0] channel_on_out,
  output logic [CHANNELS-1:0] fast_off_out,
  output logic fault_status_n_out,
  output logic [7:0] status_register_out,
  output logic [3:0] retry_remaining_out,
  output logic [CHANNELS-1:0] open_load_out,
  output logic serial_enable_out,
  output logic fail_safe_out
);
  localparam int NS = 9;

  initial begin
    if (CHANNELS != 2) $error("fault_latch_retry_control: two channels only");
  end

  // pin and comparator levels through two flip-flops
  logic [NS-1:0] s_raw;
  logic [NS-1:0] s;
  logic [CHANNELS-1:0] dir_s;
  assign s_raw = {pwr_uv_in, pwr_low6_in, pwr_por_low_in, logic_por_low_in, logic_fail_in,
                  reset_wake_n_in, load_gnd_loss_in, sys_gnd_loss_in, dev_gnd_high_in};

  // wake pin idles high, so its stages reset high and no false wake follows reset
  sync2 #(.WIDTH(NS), .RESET_VAL(`SUP_SYNC_RESET_VAL)) u_sync_sup (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(s_raw),
    .sync_out(s)
  );

  sync2 #(.WIDTH(CHANNELS)) u_sync_dir (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(direct_in),
    .sync_out(dir_s)
  );

  logic uv, low6, vpwr_low, vdd_low, vdd_fail, wake_n, lgnd, sgnd, dgnd;
  assign {uv, low6, vpwr_low, vdd_low, vdd_fail, wake_n, lgnd, sgnd, dgnd} = s;

  // previous levels for edge detection
  logic uv_q, vpwr_low_q, vdd_low_q, wake_q;
  logic [3:0] cfg_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_q <= 1'b0;
      vpwr_low_q <= 1'b1;
      vdd_low_q <= 1'b1;
      wake_q <= 1'b1; // idle awake level
    end else begin
      uv_q <= uv;
      vpwr_low_q <= vpwr_low;
      vdd_low_q <= vdd_low;
      wake_q <= wake_n | (|dir_s);
    end
  end

  logic wake_rise;
  logic por_event;
  logic supply_clear;
  assign wake_rise = (wake_n | (|dir_s)) & ~wake_q;
  // rise of either supply with the other low, or a wake with one supply up;
  // a load supply return with logic supply up does nothing
  assign por_event = (vpwr_low_q & ~vpwr_low & vdd_low_q & vdd_low)
                   | (vdd_low_q & ~vdd_low & vpwr_low_q & vpwr_low)
                   | (wake_rise & (~vpwr_low | ~vdd_low));
  assign supply_clear = (vdd_fail & ~uv) | (vdd_low & vpwr_low);

  // retry configuration register, kept while the logic supply holds
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= 4'h0;
    end else if (supply_clear) begin
      cfg_q <= 4'h0;
    end else if (retry_config_wr_in) begin
      cfg_q <= retry_config_in;
    end
  end

  logic retry_en;
  logic unlimited;
  assign retry_en = cfg_q[`CFG_RETRY_SEL_BIT];
  assign unlimited = cfg_q[`CFG_UNLIMITED_BIT];

  // reset-occurred flag, cleared by a status read, set wins
  logic por_flag_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_flag_q <= 1'b1;
    end else if (por_event) begin
      por_flag_q <= 1'b1;
    end else if (status_read_in) begin
      por_flag_q <= 1'b0;
    end
  end

  // a delatch or reset sequence arms a channel for turn-on after undervoltage
  logic [CHANNELS-1:0] armed_q;
  logic [CHANNELS-1:0] chan_on;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_q <= '1;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (por_event || delatch_in[i]) armed_q[i] <= 1'b1;
        else if (uv) armed_q[i] <= 1'b0;
      end
    end
  end

  // shared undervoltage flag: set on uv, cleared by output on (request
  // inactive at recovery) or by status read after cause gone
  logic uv_flag_q;
  logic uv_read_only_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_flag_q <= 1'b0;
      uv_read_only_q <= 1'b0;
    end else if (uv) begin
      uv_flag_q <= 1'b1;
      uv_read_only_q <= 1'b0;
    end else if (supply_clear) begin
      uv_flag_q <= 1'b0;
    end else begin
      if (uv_q && |channel_on_request_in) uv_read_only_q <= 1'b1;
      if (uv_read_only_q && status_read_in && |armed_q) uv_flag_q <= 1'b0;
      else if (!uv_read_only_q && |chan_on) uv_flag_q <= 1'b0;
    end
  end

  // per-channel fault flags and retry machines
  logic [CHANNELS-1:0] oc_q, sc_q, ot_q, ot_pend_q;
  logic [CHANNELS-1:0] retry_cond;
  logic [CHANNELS-1:0] latched;
  logic [CHANNELS-1:0] tmr_start, tmr_done;
  logic [3:0] rcnt_q [CHANNELS];
  logic [CHANNELS-1:0] exhaust_q, last_q;
  ch_state_type st_q [CHANNELS];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch
      logic fault_now;
      logic cause_gone;
      assign retry_cond[g] = oc_q[g] | sc_q[g] | ot_q[g] | uv_flag_q;
      assign fault_now = overcurrent_in[g] | short_circuit_in[g] | uv
                       | ot_pend_q[g] | sgnd;
      assign cause_gone = ~uv & ~overtemp_in[g];
      assign latched[g] = (st_q[g] == CH_LATCHED);

      // fault flags: set wins, cleared by read once cause gone and channel armed
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          oc_q[g] <= 1'b0;
          sc_q[g] <= 1'b0;
          ot_q[g] <= 1'b0;
          ot_pend_q[g] <= 1'b0;
        end else if (supply_clear) begin
          oc_q[g] <= 1'b0;
          sc_q[g] <= 1'b0;
          ot_q[g] <= 1'b0;
          ot_pend_q[g] <= 1'b0;
        end else begin
          ot_pend_q[g] <= overtemp_in[g];
          if (overcurrent_in[g] && !low6) oc_q[g] <= 1'b1;
          else if (status_read_in && armed_q[g]) oc_q[g] <= 1'b0;
          if (short_circuit_in[g] && !low6) sc_q[g] <= 1'b1;
          else if (status_read_in && armed_q[g]) sc_q[g] <= 1'b0;
          if (ot_pend_q[g] && !uv) ot_q[g] <= 1'b1;
          else if (status_read_in && armed_q[g] && !overtemp_in[g]) ot_q[g] <= 1'b0;
        end
      end

      // channel state machine
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          st_q[g] <= CH_OFF;
        end else begin
          case (st_q[g])
            CH_OFF: begin
              if (channel_on_request_in[g] && !fault_now && armed_q[g] && !dgnd) st_q[g] <= CH_ON;
            end
            CH_ON: begin
              if (!channel_on_request_in[g]) st_q[g] <= CH_OFF;
              else if (fault_now) begin
                // undervoltage is held off by the arming logic, not by latching
                if (uv && !retry_en && !sgnd) begin
                  st_q[g] <= CH_OFF;
                end else if (!retry_en || sgnd || (last_q[g] && !unlimited)) begin
                  st_q[g] <= CH_LATCHED;
                end else begin
                  st_q[g] <= CH_WAIT_CAUSE;
                end
              end
            end
            CH_WAIT_CAUSE: begin
              if (cause_gone && retry_cond[g]) st_q[g] <= CH_RETRY_WAIT;
            end
            CH_RETRY_WAIT: begin
              if (uv) st_q[g] <= CH_WAIT_CAUSE;
              else if (tmr_done[g]) st_q[g] <= channel_on_request_in[g] ? CH_ON : CH_OFF;
            end
            CH_LATCHED: begin
              if (delatch_in[g] || por_event) st_q[g] <= CH_OFF;
            end
            default: st_q[g] <= CH_OFF;
          endcase
        end
      end

      assign tmr_start[g] = (st_q[g] == CH_WAIT_CAUSE) && cause_gone && retry_cond[g];

      retry_timer #(.BASE_CYC(RETRY_BASE_CYC)) u_timer (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .start_in(tmr_start[g]),
        .period_sel_in(cfg_q[`CFG_PERIOD_LSB +: 2]),
        .done_out(tmr_done[g])
      );

      // retry counter: counts to 15, then one last retry
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          rcnt_q[g] <= 4'h0;
          exhaust_q[g] <= 1'b0;
          last_q[g] <= 1'b0;
        end else if (por_event || unlimited || dgnd) begin
          rcnt_q[g] <= 4'h0;
          exhaust_q[g] <= 1'b0;
          last_q[g] <= 1'b0;
        end else if (tmr_done[g] && st_q[g] == CH_RETRY_WAIT) begin
          if (rcnt_q[g] == `RETRY_CNT_MAX) begin
            exhaust_q[g] <= 1'b1;
            last_q[g] <= 1'b1;
          end else begin
            rcnt_q[g] <= rcnt_q[g] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // registered outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      channel_on_out <= '0;
      fast_off_out <= '0;
      fault_status_n_out <= 1'b1;
      status_register_out <= `STAT_RESET_VAL;
      retry_remaining_out <= 4'h0;
      open_load_out <= '0;
      serial_enable_out <= 1'b0;
      fail_safe_out <= 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_on_out[i] <= (st_q[i] == CH_ON) && !uv && !sgnd;
        fast_off_out[i] <= (st_q[i] == CH_ON) && (uv || sgnd || overcurrent_in[i]
                           || short_circuit_in[i] || ot_pend_q[i] || fast_sel_in);
        open_load_out[i] <= lgnd;
      end
      fault_status_n_out <= !(uv || (|latched));
      status_register_out <= {1'b0, por_flag_q, exhaust_q[1], exhaust_q[0], uv_flag_q,
                              ot_q[0] | ot_q[1], sc_q[0] | sc_q[1], oc_q[0] | oc_q[1]};
      retry_remaining_out <= rcnt_q[0];
      serial_enable_out <= !vdd_low && !dgnd;
      fail_safe_out <= dgnd;
    end
  end
  assign chan_on = channel_on_out;
endmodule : fault_latch_retry_control
`default_nettype wire

// ==== sim/host_model.sv ====
/*
  controller model: status reads and retry config writes as one-cycle pulses.
  assumes the supervisor samples these on rising edges of mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk_in,
  output logic status_read_out,
  output logic [3:0] retry_config_out,
  output logic retry_config_wr_out,
  output logic reset_wake_n_out
);
  // wake line held high so no wake rise sets the reset flag
  assign reset_wake_n_out = 1'b1;
  // idle strobes from time zero
  initial begin
    status_read_out = 1'b0;
    retry_config_out = 4'h0;
    retry_config_wr_out = 1'b0;
  end
  // one-cycle status read strobe
  task automatic read_status();
    @(posedge mclk_in);
    status_read_out <= 1'b1;
    @(posedge mclk_in);
    status_read_out <= 1'b0;
  endtask : read_status
  // config value held with its write strobe for one edge
  task automatic write_config(input logic [3:0] v);
    @(posedge mclk_in);
    retry_config_out <= v;
    retry_config_wr_out <= 1'b1;
    @(posedge mclk_in);
    retry_config_wr_out <= 1'b0;
  endtask : write_config
endmodule : host_model
`default_nettype wire

// ==== sim/fault_ctl_sva.sv ====
/*
  concurrent checks on the supervisor ports.
  assumes it is bound into the supervisor module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_ctl_sva #(
  parameter int CHANNELS = 2
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pwr_uv_in,
  input wire logic pwr_low6_in,
  input wire logic logic_fail_in,
  input wire logic logic_por_low_in,
  input wire logic sys_gnd_loss_in,
  input wire logic load_gnd_loss_in,
  input wire logic dev_gnd_high_in,
  input wire logic [CHANNELS-1:0] overcurrent_in,
  input wire logic [CHANNELS-1:0] channel_on_out,
  input wire logic [CHANNELS-1:0] fast_off_out,
  input wire logic [CHANNELS-1:0] open_load_out,
  input wire logic fault_status_n_out,
  input wire logic [7:0] status_register_out,
  input wire logic serial_enable_out,
  input wire logic fail_safe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // supply and ground conditions, allowing the pin synchroniser delay
  property p_uv_off;
    pwr_uv_in [*6] |-> channel_on_out == '0 && !fault_status_n_out && status_register_out[3];
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv not handled");
  property p_sys_gnd;
    sys_gnd_loss_in [*6] |-> channel_on_out == '0;
  endproperty
  a_sys_gnd: assert property (p_sys_gnd) else $error("on after ground loss");
  property p_load_gnd;
    load_gnd_loss_in [*6] |-> open_load_out[0];
  endproperty
  a_load_gnd: assert property (p_load_gnd) else $error("no open load");
  property p_dev_gnd;
    dev_gnd_high_in [*6] |-> fail_safe_out && !serial_enable_out;
  endproperty
  a_dev_gnd: assert property (p_dev_gnd) else $error("no fail-safe");
  property p_serial;
    (!dev_gnd_high_in && !logic_fail_in && !logic_por_low_in) [*6] |-> serial_enable_out;
  endproperty
  a_serial: assert property (p_serial) else $error("serial lost");
  property p_low6;
    pwr_low6_in [*6] |=> !$rose(status_register_out[2]);
  endproperty
  a_low6: assert property (p_low6) else $error("overtemp shown below 6V");
  // fault on a running channel turns it off at the fast rate
  property p_fault_off;
    $rose(overcurrent_in[0]) && channel_on_out[0] |-> ##[1:3] !channel_on_out[0];
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault not off");
  property p_fast;
    $rose(overcurrent_in[0]) && channel_on_out[0] |-> ##[0:3] fast_off_out[0];
  endproperty
  a_fast: assert property (p_fast) else $error("slow fault off");
endmodule : fault_ctl_sva
bind fault_latch_retry_control fault_ctl_sva #(.CHANNELS(CHANNELS)) fault_ctl_sva_inst (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pwr_uv_in(pwr_uv_in), .pwr_low6_in(pwr_low6_in),
  .logic_fail_in(logic_fail_in), .logic_por_low_in(logic_por_low_in),
  .sys_gnd_loss_in(sys_gnd_loss_in), .load_gnd_loss_in(load_gnd_loss_in),
  .dev_gnd_high_in(dev_gnd_high_in), .overcurrent_in(overcurrent_in),
  .channel_on_out(channel_on_out), .fast_off_out(fast_off_out), .open_load_out(open_load_out),
  .fault_status_n_out(fault_status_n_out), .status_register_out(status_register_out),
  .serial_enable_out(serial_enable_out), .fail_safe_out(fail_safe_out)
);
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  self-checking bench for the fault supervisor against a flag model.
  assumes a retry base of 4 cycles and the host model on the config side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctl_regs.svh"
module tb_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pwr_uv_in = 1'b0;
  logic pwr_low6_in = 1'b0;
  logic sys_gnd_loss_in = 1'b0;
  logic load_gnd_loss_in = 1'b0;
  logic dev_gnd_high_in = 1'b0;
  logic pwr_por_low_in = 1'b0;
  logic logic_por_low_in = 1'b0;
  logic logic_fail_in = 1'b0;
  logic fast_sel_in = 1'b0;
  logic [1:0] overcurrent_in = 2'h0;
  logic [1:0] short_circuit_in = 2'h0;
  logic [1:0] overtemp_in = 2'h0;
  logic [1:0] channel_on_request_in = 2'h0;
  logic [1:0] delatch_in = 2'h0;
  logic status_read_in, retry_config_wr_in, reset_wake_n_in;
  logic [3:0] retry_config_in;
  logic [1:0] channel_on_out, fast_off_out, open_load_out;
  logic fault_status_n_out, serial_enable_out, fail_safe_out;
  logic [7:0] status_register_out, m_stat, lf;
  logic [3:0] retry_remaining_out;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // 125 MHz clock
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  fault_latch_retry_control #(.CHANNELS(2), .RETRY_BASE_CYC(4)) fault_latch_retry_control_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pwr_uv_in(pwr_uv_in), .pwr_low6_in(pwr_low6_in),
    .pwr_por_low_in(pwr_por_low_in), .logic_por_low_in(logic_por_low_in),
    .logic_fail_in(logic_fail_in),
    .reset_wake_n_in(reset_wake_n_in), .direct_in(2'h0), .load_gnd_loss_in(load_gnd_loss_in),
    .sys_gnd_loss_in(sys_gnd_loss_in), .dev_gnd_high_in(dev_gnd_high_in),
    .overcurrent_in(overcurrent_in), .short_circuit_in(short_circuit_in),
    .overtemp_in(overtemp_in), .channel_on_request_in(channel_on_request_in),
    .delatch_in(delatch_in), .status_read_in(status_read_in), .retry_config_in(retry_config_in),
    .retry_config_wr_in(retry_config_wr_in), .fast_sel_in(fast_sel_in),
    .channel_on_out(channel_on_out), .fast_off_out(fast_off_out),
    .fault_status_n_out(fault_status_n_out), .status_register_out(status_register_out),
    .retry_remaining_out(retry_remaining_out), .open_load_out(open_load_out),
    .serial_enable_out(serial_enable_out), .fail_safe_out(fail_safe_out)
  );
  host_model host_model_inst (
    .mclk_in(mclk_in), .status_read_out(status_read_in), .retry_config_out(retry_config_in),
    .retry_config_wr_out(retry_config_wr_in), .reset_wake_n_out(reset_wake_n_in)
  );
  // pseudo-random source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : wt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle delatch of channel 0, then settle
  task automatic delatch0();
    @(posedge mclk_in);
    delatch_in <= 2'b01;
    @(posedge mclk_in);
    delatch_in <= 2'b00;
    wt(4);
  endtask : delatch0
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    int k;
    int n;
    int p;
    lf = 8'h37;
    repeat (4) @(posedge mclk_in);
    #1;
    chk(status_register_out, `STAT_RESET_VAL);
    chk(8'(fault_status_n_out), 8'h01);
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wt(6);
    m_stat = `STAT_RESET_VAL;
    chk(status_register_out, m_stat);
    host_model_inst.read_status();
    wt(3);
    m_stat[`STAT_POR_BIT] = 1'b0;
    chk(status_register_out, m_stat);
    $display("test reset done");
    // latchable faults with retry off: latch, delatch, read clears
    host_model_inst.write_config(4'h0);
    @(posedge mclk_in);
    channel_on_request_in <= 2'b01;
    wt(4);
    chk(8'(channel_on_out), 8'h01);
    for (k = 0; k < 3; k++) begin
      @(posedge mclk_in);
      overcurrent_in <= {1'b0, k == 0};
      short_circuit_in <= {1'b0, k == 1};
      overtemp_in <= {1'b0, k == 2};
      wt(4);
      m_stat[k] = 1'b1;
      chk(8'(channel_on_out), 8'h00);
      chk(8'(fault_status_n_out), 8'h00);
      chk(status_register_out, m_stat);
      @(posedge mclk_in);
      overcurrent_in <= 2'h0;
      short_circuit_in <= 2'h0;
      overtemp_in <= 2'h0;
      wt(6);
      chk(8'(channel_on_out), 8'h00);
      delatch0();
      chk(8'(channel_on_out), 8'h01);
      host_model_inst.read_status();
      wt(3);
      m_stat[k] = 1'b0;
      chk(status_register_out, m_stat);
      chk(8'(fault_status_n_out), 8'h01);
    end
    $display("test latch done");
    // undervoltage below 6 V, recovery without request, then delatch
    @(posedge mclk_in);
    pwr_uv_in <= 1'b1;
    pwr_low6_in <= 1'b1;
    wt(8);
    m_stat[`STAT_UV_BIT] = 1'b1;
    chk(8'(channel_on_out), 8'h00);
    chk(8'(fault_status_n_out), 8'h00);
    chk(status_register_out, m_stat);
    chk(8'(serial_enable_out), 8'h01);
    @(posedge mclk_in);
    pwr_uv_in <= 1'b0;
    pwr_low6_in <= 1'b0;
    channel_on_request_in <= 2'b00;
    wt(8);
    chk(8'(fault_status_n_out), 8'h01);
    chk(status_register_out, m_stat);
    @(posedge mclk_in);
    channel_on_request_in <= 2'b01;
    delatch0();
    chk(8'(channel_on_out), 8'h01);
    m_stat[`STAT_UV_BIT] = 1'b0;
    chk(status_register_out, m_stat);
    host_model_inst.read_status();
    wt(3);
    chk(status_register_out, m_stat);
    // undervoltage with the request held: stays off until delatch, read clears
    @(posedge mclk_in);
    pwr_uv_in <= 1'b1;
    wt(8);
    @(posedge mclk_in);
    pwr_uv_in <= 1'b0;
    wt(8);
    m_stat[`STAT_UV_BIT] = 1'b1;
    chk(8'(channel_on_out), 8'h00);
    chk(status_register_out, m_stat);
    delatch0();
    chk(8'(channel_on_out), 8'h01);
    chk(status_register_out, m_stat);
    host_model_inst.read_status();
    wt(3);
    m_stat[`STAT_UV_BIT] = 1'b0;
    chk(status_register_out, m_stat);
    $display("test uv done");
    // ground faults
    @(posedge mclk_in);
    sys_gnd_loss_in <= 1'b1;
    wt(8);
    chk(8'(channel_on_out), 8'h00);
    @(posedge mclk_in);
    sys_gnd_loss_in <= 1'b0;
    load_gnd_loss_in <= 1'b1;
    wt(8);
    chk(8'(open_load_out[0]), 8'h01);
    @(posedge mclk_in);
    load_gnd_loss_in <= 1'b0;
    dev_gnd_high_in <= 1'b1;
    wt(8);
    chk(8'(fail_safe_out), 8'h01);
    chk(8'(serial_enable_out), 8'h00);
    @(posedge mclk_in);
    dev_gnd_high_in <= 1'b0;
    wt(8);
    $display("test ground done");
    // retry after a passing fault, random period select
    lf = lfsr(lf);
    p = lf[1:0];
    host_model_inst.write_config({lf[1:0], 2'b01});
    delatch0();
    @(posedge mclk_in);
    overcurrent_in <= 2'b01;
    repeat (2) @(posedge mclk_in);
    overcurrent_in <= 2'b00;
    wt(1);
    n = 0;
    while (channel_on_out[0] !== 1'b0 && n < 10) begin
      wt(1);
      n++;
    end
    n = 0;
    while (channel_on_out[0] !== 1'b1 && n < 100) begin
      wt(1);
      n++;
    end
    chk(8'(n >= 4 * (p + 1) - 2 && n <= 4 * (p + 1) + 6), 8'h01);
    chk(8'(retry_remaining_out), 8'h01);
    m_stat[0] = 1'b1;
    chk(status_register_out, m_stat);
    chk(8'(fast_off_out), 8'h00);
    $display("test retry done");
    // slew override, supply reset sequences, logic supply failure
    @(posedge mclk_in);
    fast_sel_in <= 1'b1;
    wt(2);
    chk(8'(fast_off_out), 8'h01);
    @(posedge mclk_in);
    fast_sel_in <= 1'b0;
    pwr_por_low_in <= 1'b1;
    logic_por_low_in <= 1'b1;
    wt(8);
    m_stat[0] = 1'b0;
    chk(status_register_out, m_stat);
    @(posedge mclk_in);
    logic_por_low_in <= 1'b0;
    wt(6);
    m_stat[`STAT_POR_BIT] = 1'b1;
    chk(status_register_out, m_stat);
    chk(8'(retry_remaining_out), 8'h00);
    host_model_inst.read_status();
    @(posedge mclk_in);
    pwr_por_low_in <= 1'b0;
    wt(6);
    m_stat[`STAT_POR_BIT] = 1'b0;
    chk(status_register_out, m_stat);
    @(posedge mclk_in);
    overcurrent_in <= 2'b01;
    @(posedge mclk_in);
    overcurrent_in <= 2'b00;
    wt(4);
    m_stat[0] = 1'b1;
    chk(8'(channel_on_out), 8'h00);
    chk(status_register_out, m_stat);
    @(posedge mclk_in);
    logic_fail_in <= 1'b1;
    wt(6);
    m_stat[0] = 1'b0;
    chk(status_register_out, m_stat);
    @(posedge mclk_in);
    logic_fail_in <= 1'b0;
    wt(3);
    $display("test supply done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
